// file: logic/sefl_pkg.sv
package sefl_pkg;

  // register offsets
  localparam logic [7:0] ADDR_DATA_STATUS   = 8'h00;
  localparam logic [7:0] ADDR_OUT_FIRST     = 8'h01;
  localparam logic [7:0] ADDR_OUT_LAST      = 8'h05;
  localparam logic [7:0] ADDR_INT_SOURCE    = 8'h12;
  localparam logic [7:0] ADDR_DATA_EVT_CFG  = 8'h13;
  localparam logic [7:0] ADDR_SEA_LEVEL_HI  = 8'h14;
  localparam logic [7:0] ADDR_SEA_LEVEL_LO  = 8'h15;
  localparam logic [7:0] ADDR_P_TARGET_HI   = 8'h16;
  localparam logic [7:0] ADDR_P_TARGET_LO   = 8'h17;

  // interrupt source bit positions
  localparam int SRC_DATA_READY  = 7;
  localparam int SRC_QUEUE       = 6;
  localparam int SRC_P_WINDOW    = 5;
  localparam int SRC_T_WINDOW    = 4;
  localparam int SRC_P_THRESHOLD = 3;
  localparam int SRC_T_THRESHOLD = 2;
  localparam int SRC_P_CHANGE    = 1;
  localparam int SRC_T_CHANGE    = 0;
  localparam int SRC_COUNT       = 8;

  // data event configuration bit positions
  localparam int CFG_EVENT_MODE = 2;
  localparam int CFG_P_EVENT_EN = 1;
  localparam int CFG_T_EVENT_EN = 0;

  // reset values
  localparam logic [7:0]  RST_INT_SOURCE  = 8'h00;
  localparam logic [2:0]  RST_EVT_CFG     = 3'h0;
  // 101326 Pa in 2 Pa units
  localparam logic [15:0] RST_SEA_LEVEL   = 16'hC5E7;
  localparam logic [15:0] RST_P_TARGET    = 16'h0000;
  localparam logic [7:0]  RST_READ_DATA   = 8'h00;
  localparam logic [5:0]  WATERMARK_OFF   = 6'h00;

  // host register access, one byte per strobe
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } sefl_reg_req_t;

  // measurement results from the datapath
  typedef struct packed {
    logic [15:0] pressure;
    logic [7:0]  temperature;
    logic        newPressure;
    logic        newTemperature;
    logic        overwrite;
    logic        ready;
  } sefl_meas_t;

  // configuration held elsewhere in the device
  typedef struct packed {
    logic        altitudeMode;
    logic        dataReadyIntEn;
    logic        queueMode;
    logic [5:0]  queueCount;
    logic [5:0]  queueWatermark;
    logic        queueOverflow;
    logic [15:0] pressureWindow;
    logic [7:0]  temperatureTarget;
    logic [7:0]  temperatureWindow;
    logic        pressureChange;
    logic        temperatureChange;
  } sefl_cfg_t;

endpackage : sefl_pkg

// file: logic/sefl_src_flag.sv
`timescale 1ns/1ps
module sefl_src_flag (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic ce,
  // condition and clear
  input  wire logic cond,
  input  wire logic clr,
  // sticky flag
  output logic      flag
);

  logic condPrev;
  logic rise;

  assign rise = cond & ~condPrev;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      condPrev <= 1'b0;
      flag     <= 1'b0;
    end else if (ce) begin
      condPrev <= cond;
      // set wins over a clear in the same cycle
      if (rise) begin
        flag <= 1'b1;
      end else if (clr) begin
        flag <= 1'b0;
      end
    end
  end

endmodule : sefl_src_flag

// file: logic/sefl_event_flags.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module sefl_event_flags (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  input  wire logic                   ce,
  // register access
  input  wire sefl_pkg::sefl_reg_req_t regReq,
  output logic [7:0]                  regRdData,
  // datapath inputs
  input  wire sefl_pkg::sefl_meas_t   meas,
  input  wire sefl_pkg::sefl_cfg_t    cfg,
  // results
  output logic [7:0]                  intSource,
  output logic                        dataEvent,
  output logic [15:0]                 seaLevelRef,
  output logic [15:0]                 pressureTarget
);
  import sefl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  logic [2:0] evtCfg;
  logic       hitStatus;
  logic       hitOutput;
  logic       hitIntSrc;
  logic       hitCfg;
  logic       hitSeaHi;
  logic       hitSeaLo;
  logic       hitTgtHi;
  logic       hitTgtLo;
  logic       wrCfg;
  logic       wrSeaHi;
  logic       wrSeaLo;
  logic       wrTgtHi;
  logic       wrTgtLo;

  // address decode, shared by the write and read paths
  assign hitStatus = (regReq.addr == ADDR_DATA_STATUS);
  assign hitOutput = (regReq.addr >= ADDR_OUT_FIRST) &&
                     (regReq.addr <= ADDR_OUT_LAST);
  assign hitIntSrc = (regReq.addr == ADDR_INT_SOURCE);
  assign hitCfg    = (regReq.addr == ADDR_DATA_EVT_CFG);
  assign hitSeaHi  = (regReq.addr == ADDR_SEA_LEVEL_HI);
  assign hitSeaLo  = (regReq.addr == ADDR_SEA_LEVEL_LO);
  assign hitTgtHi  = (regReq.addr == ADDR_P_TARGET_HI);
  assign hitTgtLo  = (regReq.addr == ADDR_P_TARGET_LO);

  assign wrCfg   = regReq.wr && hitCfg;
  assign wrSeaHi = regReq.wr && hitSeaHi;
  assign wrSeaLo = regReq.wr && hitSeaLo;
  assign wrTgtHi = regReq.wr && hitTgtHi;
  assign wrTgtLo = regReq.wr && hitTgtLo;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      evtCfg <= RST_EVT_CFG;
    end else if (ce && wrCfg) begin
      evtCfg <= regReq.wdata[2:0];
    end
  end

  // each byte lands on its own, no staging between halves
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seaLevelRef <= RST_SEA_LEVEL;
    end else if (ce) begin
      if (wrSeaHi) begin
        seaLevelRef[15:8] <= regReq.wdata;
      end
      if (wrSeaLo) begin
        seaLevelRef[7:0] <= regReq.wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pressureTarget <= RST_P_TARGET;
    end else if (ce) begin
      if (wrTgtHi) begin
        pressureTarget[15:8] <= regReq.wdata;
      end
      if (wrTgtLo) begin
        pressureTarget[7:0] <= regReq.wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path and read side effects
  logic       rdStatus;
  logic       rdOutput;
  logic       rdIntSource;
  logic       rdQueueStatus;
  logic       statusSeen;
  logic       clrDataReady;
  logic [7:0] next_regRdData;

  assign rdStatus      = regReq.rd && !cfg.queueMode && hitStatus;
  assign rdOutput      = regReq.rd && hitOutput;
  assign rdIntSource   = regReq.rd && hitIntSrc;
  assign rdQueueStatus = regReq.rd && cfg.queueMode && hitStatus;
  assign clrDataReady  = rdOutput && statusSeen;

  assign next_regRdData =
      hitIntSrc ? intSource :
      hitCfg    ? {5'h00, evtCfg} :
      hitSeaHi  ? seaLevelRef[15:8] :
      hitSeaLo  ? seaLevelRef[7:0] :
      hitTgtHi  ? pressureTarget[15:8] :
      hitTgtLo  ? pressureTarget[7:0] :
      RST_READ_DATA;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdData  <= RST_READ_DATA;
      statusSeen <= 1'b0;
    end else if (ce) begin
      if (regReq.rd) begin
        regRdData <= next_regRdData;
      end
      // status read arms the clear, output read completes it
      if (rdStatus) begin
        statusSeen <= 1'b1;
      end else if (rdOutput) begin
        statusSeen <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pressure alerter arithmetic
  logic signed [17:0] pMeas;
  logic signed [17:0] pTgt;
  logic signed [17:0] pWnd;
  logic signed [17:0] pUpper;
  logic signed [17:0] pLower;
  logic               pWndZero;
  logic [2:0]         pAbove;
  logic [2:0]         pAbovePrev;
  logic               pPrimed;
  logic               pInWindow;
  logic               pCross;
  logic               next_pCross;
  logic               pCrossUp;
  logic               pCrossMid;
  logic               pCrossLow;
  logic               next_pInWindow;

  // altitude signed meters, pressure unsigned 2 Pa units
  assign pMeas = cfg.altitudeMode ? {{2{meas.pressure[15]}}, meas.pressure}
                                  : {2'b00, meas.pressure};
  assign pTgt  = cfg.altitudeMode ?
                 {{2{pressureTarget[15]}}, pressureTarget}
               : {2'b00, pressureTarget};
  assign pWnd     = {2'b00, cfg.pressureWindow};
  assign pUpper   = pTgt + pWnd;
  assign pLower   = pTgt - pWnd;
  assign pWndZero = (cfg.pressureWindow == 16'h0000);
  assign pAbove   = {pMeas > pUpper, pMeas > pTgt, pMeas > pLower};
  assign pCrossUp  = pAbove[2] != pAbovePrev[2];
  assign pCrossMid = pAbove[1] != pAbovePrev[1];
  assign pCrossLow = pAbove[0] != pAbovePrev[0];
  // zero window leaves only the centre threshold
  assign next_pCross = meas.newPressure && pPrimed &&
                       (pCrossMid ||
                        (!pWndZero && (pCrossUp || pCrossLow)));
  assign next_pInWindow = !pWndZero && (pMeas >= pLower) &&
                          (pMeas <= pUpper);

  ////////////////////////////////////////////////////////////////////////////
  // temperature alerter arithmetic
  logic signed [9:0] tMeas;
  logic signed [9:0] tTgt;
  logic signed [9:0] tWnd;
  logic signed [9:0] tUpper;
  logic signed [9:0] tLower;
  logic              tWndZero;
  logic [2:0]        tAbove;
  logic [2:0]        tAbovePrev;
  logic              tPrimed;
  logic              tInWindow;
  logic              tCross;
  logic              next_tCross;
  logic              tCrossUp;
  logic              tCrossMid;
  logic              tCrossLow;
  logic              next_tInWindow;

  assign tMeas  = {{2{meas.temperature[7]}}, meas.temperature};
  assign tTgt   = {{2{cfg.temperatureTarget[7]}},
                   cfg.temperatureTarget};
  assign tWnd   = {2'b00, cfg.temperatureWindow};
  assign tUpper = tTgt + tWnd;
  assign tLower = tTgt - tWnd;
  assign tWndZero = (cfg.temperatureWindow == 8'h00);
  assign tAbove = {tMeas > tUpper, tMeas > tTgt, tMeas > tLower};
  assign tCrossUp  = tAbove[2] != tAbovePrev[2];
  assign tCrossMid = tAbove[1] != tAbovePrev[1];
  assign tCrossLow = tAbove[0] != tAbovePrev[0];
  // zero window leaves only the centre threshold
  assign next_tCross = meas.newTemperature && tPrimed &&
                       (tCrossMid ||
                        (!tWndZero && (tCrossUp || tCrossLow)));
  assign next_tInWindow = !tWndZero && (tMeas >= tLower) &&
                          (tMeas <= tUpper);

  // the first sample after reset only primes the crossing history
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pAbovePrev <= 3'h0;
      pPrimed    <= 1'b0;
      pInWindow  <= 1'b0;
      pCross     <= 1'b0;
    end else if (ce) begin
      pCross <= next_pCross;
      if (meas.newPressure) begin
        pAbovePrev <= pAbove;
        pPrimed    <= 1'b1;
        pInWindow  <= next_pInWindow;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tAbovePrev <= 3'h0;
      tPrimed    <= 1'b0;
      tInWindow  <= 1'b0;
      tCross     <= 1'b0;
    end else if (ce) begin
      tCross <= next_tCross;
      if (meas.newTemperature) begin
        tAbovePrev <= tAbove;
        tPrimed    <= 1'b1;
        tInWindow  <= next_tInWindow;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data event generator
  logic [15:0] pLast;
  logic [7:0]  tLast;
  logic        pEvent;
  logic        tEvent;
  logic        next_dataEvent;

  assign pEvent = meas.newPressure && evtCfg[CFG_P_EVENT_EN] &&
                  (!evtCfg[CFG_EVENT_MODE] ||
                   (meas.pressure != pLast));
  assign tEvent = meas.newTemperature && evtCfg[CFG_T_EVENT_EN] &&
                  (!evtCfg[CFG_EVENT_MODE] ||
                   (meas.temperature != tLast));
  assign next_dataEvent = pEvent || tEvent;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dataEvent <= 1'b0;
    end else if (ce) begin
      dataEvent <= next_dataEvent;
    end
  end

  // last value of each kind, compared in change mode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pLast <= 16'h0000;
      tLast <= 8'h00;
    end else if (ce) begin
      if (meas.newPressure) begin
        pLast <= meas.pressure;
      end
      if (meas.newTemperature) begin
        tLast <= meas.temperature;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt source bits
  logic [SRC_COUNT-1:0] srcCond;
  logic [SRC_COUNT-1:0] srcClr;
  logic                 wmarkHit;

  assign wmarkHit = (cfg.queueWatermark != WATERMARK_OFF) &&
                    (cfg.queueCount == cfg.queueWatermark);

  assign srcCond[SRC_DATA_READY]  = cfg.dataReadyIntEn &&
                                    (meas.overwrite || meas.ready);
  assign srcCond[SRC_QUEUE]       = cfg.queueOverflow || wmarkHit;
  assign srcCond[SRC_P_WINDOW]    = pInWindow;
  assign srcCond[SRC_T_WINDOW]    = tInWindow;
  assign srcCond[SRC_P_THRESHOLD] = pCross;
  assign srcCond[SRC_T_THRESHOLD] = tCross;
  assign srcCond[SRC_P_CHANGE]    = cfg.pressureChange;
  assign srcCond[SRC_T_CHANGE]    = cfg.temperatureChange;

  assign srcClr[SRC_DATA_READY]  = clrDataReady;
  assign srcClr[SRC_QUEUE]       = rdQueueStatus;
  assign srcClr[SRC_P_WINDOW]    = rdIntSource;
  assign srcClr[SRC_T_WINDOW]    = rdIntSource;
  assign srcClr[SRC_P_THRESHOLD] = rdIntSource;
  assign srcClr[SRC_T_THRESHOLD] = rdIntSource;
  assign srcClr[SRC_P_CHANGE]    = rdIntSource;
  assign srcClr[SRC_T_CHANGE]    = rdIntSource;

  // one edge-set sticky flop per source bit, all reset to zero
  for (genvar i = 0; i < SRC_COUNT; i++) begin : g_src
    sefl_src_flag u_flag (
      .clk   (clk),
      .rst_b (rst_b),
      .ce    (ce),
      .cond  (srcCond[i]),
      .clr   (srcClr[i]),
      .flag  (intSource[i])
    );
  end

endmodule : sefl_event_flags

// file: sim/sefl_host_model.sv
`timescale 1ns/1ps
module sefl_host_model (
  // bus
  input  wire logic               clk,
  input  wire logic [7:0]         regRdData,
  output sefl_pkg::sefl_reg_req_t regReq
);
  import sefl_pkg::*;
  initial regReq = '0;
  // released address and data show the inverse of the last value
  task wr(input logic [7:0] a, dat);
    @(posedge clk);
    #1;
    regReq = '{a, 1'b1, 1'b0, dat};
    @(posedge clk);
    #1;
    regReq = '{~a, 1'b0, 1'b0, ~dat};
  endtask : wr
  task rd(input logic [7:0] a, output logic [7:0] dat);
    @(posedge clk);
    #1;
    regReq = '{a, 1'b0, 1'b1, ~regReq.wdata};
    @(posedge clk);
    #1;
    dat = regRdData;
    regReq = '{~a, 1'b0, 1'b0, ~regReq.wdata};
  endtask : rd
endmodule : sefl_host_model

// file: sim/sefl_event_flags_properties.sv
`timescale 1ns/1ps
module sefl_event_flags_properties (
  // clock and reset
  input wire logic                    clk,
  input wire logic                    rst_b,
  input wire logic                    ce,
  // register access
  input wire sefl_pkg::sefl_reg_req_t regReq,
  input wire logic [7:0]              regRdData,
  // datapath
  input wire sefl_pkg::sefl_meas_t    meas,
  input wire sefl_pkg::sefl_cfg_t     cfg,
  // results
  input wire logic [7:0]              intSource,
  input wire logic                    dataEvent,
  input wire logic [15:0]             seaLevelRef,
  input wire logic [15:0]             pressureTarget
);
  import sefl_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_rd_source: assert property (
    ce && regReq.rd && regReq.addr == ADDR_INT_SOURCE
    |=> regRdData == $past(intSource)) else $error("source readback");
  a_drdy_rise: assert property (
    ce && cfg.dataReadyIntEn && meas.ready && !$past(meas.ready)
    && !$past(meas.overwrite) |=> intSource[SRC_DATA_READY])
    else $error("data ready not set");
  a_queue_rise: assert property (
    ce && cfg.queueOverflow && !$past(cfg.queueOverflow)
    && $past(cfg.queueWatermark) == WATERMARK_OFF
    |=> intSource[SRC_QUEUE]) else $error("queue bit not set");
  a_pchg_set: assert property (
    ce && cfg.pressureChange && !$past(cfg.pressureChange)
    |=> intSource[SRC_P_CHANGE]) else $error("change bit not set");
  a_change_clear: assert property (
    ce && regReq.rd && regReq.addr == ADDR_INT_SOURCE
    && !cfg.pressureChange && !cfg.temperatureChange
    |=> intSource[1:0] == 2'h0) else $error("change bits kept");
  a_event_cause: assert property (
    dataEvent |-> $past(meas.newPressure | meas.newTemperature))
    else $error("event without sample");
  a_sea_write: assert property (
    ce && regReq.wr && regReq.addr == ADDR_SEA_LEVEL_HI
    |=> seaLevelRef[15:8] == $past(regReq.wdata))
    else $error("sea level write lost");
  a_tgt_write: assert property (
    ce && regReq.wr && regReq.addr == ADDR_P_TARGET_LO
    |=> pressureTarget[7:0] == $past(regReq.wdata))
    else $error("target write lost");
  a_tw_zero: assert property (
    $rose(intSource[SRC_T_WINDOW]) |-> $past(cfg.temperatureWindow, 2)
    != 8'h00) else $error("window alert with zero window");
endmodule : sefl_event_flags_properties
////////////////////////////////////////
bind sefl_event_flags sefl_event_flags_properties u_prop (
  .clk(clk), .rst_b(rst_b), .ce(ce), .regReq(regReq),
  .regRdData(regRdData), .meas(meas), .cfg(cfg),
  .intSource(intSource), .dataEvent(dataEvent),
  .seaLevelRef(seaLevelRef), .pressureTarget(pressureTarget));

// file: sim/sefl_event_flags_tb.sv
`timescale 1ns/1ps
module sefl_event_flags_tb;
  import sefl_pkg::*;
  logic          clk = 0;
  logic          rst_b = 0;
  logic          ce = 1;
  sefl_reg_req_t regReq;
  sefl_meas_t    meas = '0;
  sefl_cfg_t     cfg = '0;
  logic [7:0]    regRdData, intSource, d;
  logic          dataEvent;
  logic [15:0]   seaLevelRef, pressureTarget;
  int            error_cnt = 0;
  int            n_compared = 0;
  logic [7:0]    ra[6] = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17};
  logic [7:0]    re[6] = '{8'h00, 8'h00, 8'hC5, 8'hE7, 8'h00, 8'h00};
  always #25 clk = ~clk;
  sefl_host_model host (.clk(clk), .regRdData(regRdData), .regReq(regReq));
  sefl_event_flags dut (.clk(clk), .rst_b(rst_b), .ce(ce),
    .regReq(regReq), .regRdData(regRdData), .meas(meas), .cfg(cfg),
    .intSource(intSource), .dataEvent(dataEvent),
    .seaLevelRef(seaLevelRef), .pressureTarget(pressureTarget));
  ////////////////////////////////////////
  task chk(input string n, input logic [15:0] e, s);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task rdc(input logic [7:0] a, e);
    host.rd(a, d);
    chk("readback", {8'h00, e}, {8'h00, d});
  endtask : rdc
  // one sample, then dataEvent is settled
  task smp(input logic [15:0] p, input logic [7:0] t, input logic np, nt);
    meas.pressure = p;
    meas.temperature = t;
    meas.newPressure = np;
    meas.newTemperature = nt;
    tick(1);
    meas.newPressure = 0;
    meas.newTemperature = 0;
  endtask : smp
  task results;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results
  initial begin
    #400000;
    error_cnt++;
    results();
  end
  initial begin
    tick(4);
    rst_b = 1;
    foreach (ra[i]) rdc(ra[i], re[i]);
    host.wr(8'h13, 8'hFF);
    rdc(8'h13, 8'h07);
    host.wr(8'h12, 8'hFF);
    rdc(8'h12, 8'h00);
    rdc(8'h30, 8'h00);
    host.wr(8'h14, 8'h12);
    host.wr(8'h15, 8'h34);
    chk("seaLevelRef", 16'h1234, seaLevelRef);
    ce = 0;
    host.wr(8'h14, 8'hAB);
    chk("frozen", 16'h1234, seaLevelRef);
    ce = 1;
    host.wr(8'h16, 8'h00);
    host.wr(8'h17, 8'h64);
    chk("pressureTarget", 16'h0064, pressureTarget);
    cfg.dataReadyIntEn = 1;
    meas.ready = 1;
    tick(1);
    rdc(8'h12, 8'h80);
    host.rd(8'h00, d);
    chk("drdy", 1, intSource[7]);
    host.rd(8'h01, d);
    chk("drdy", 0, intSource[7]);
    meas.ready = 0;
    tick(1);
    meas.overwrite = 1;
    tick(1);
    host.rd(8'h01, d);
    chk("drdy", 1, intSource[7]);
    host.rd(8'h00, d);
    host.rd(8'h01, d);
    chk("drdy", 0, intSource[7]);
    meas.overwrite = 0;
    cfg.queueOverflow = 1;
    tick(1);
    chk("queue", 1, intSource[6]);
    cfg.queueMode = 1;
    host.rd(8'h00, d);
    chk("queue", 0, intSource[6]);
    cfg.queueOverflow = 0;
    tick(2);
    chk("queue", 0, intSource[6]);
    cfg.queueWatermark = 6'h05;
    cfg.queueCount = 6'h04;
    tick(2);
    chk("queue", 0, intSource[6]);
    cfg.queueCount = 6'h05;
    tick(1);
    chk("queue", 1, intSource[6]);
    host.rd(8'h00, d);
    cfg.queueMode = 0;
    cfg.pressureWindow = 16'h000A;
    smp(16'd120, 8'h00, 1, 0);
    smp(16'd105, 8'h00, 1, 0);
    tick(3);
    chk("pwin", 3'b101, intSource[5:3]);
    rdc(8'h12, 8'h28);
    chk("cleared", 8'h00, intSource);
    cfg.pressureWindow = 16'h0000;
    smp(16'd120, 8'h00, 1, 0);
    smp(16'd105, 8'h00, 1, 0);
    tick(3);
    chk("pzero", 8'h00, intSource);
    cfg.altitudeMode = 1;
    host.wr(8'h16, 8'hFF);
    host.wr(8'h17, 8'hFE);
    cfg.pressureWindow = 16'h0005;
    smp(16'h0002, 8'h00, 1, 0);
    tick(3);
    chk("alt", 1, intSource[5]);
    host.rd(8'h12, d);
    cfg.altitudeMode = 0;
    cfg.temperatureTarget = 8'd20;
    smp(16'h0002, 8'd20, 0, 1);
    tick(3);
    chk("twin", 0, intSource[4]);
    cfg.temperatureWindow = 8'd2;
    smp(16'h0002, 8'd21, 0, 1);
    tick(3);
    chk("twin", 3'b101, intSource[4:2]);
    host.rd(8'h12, d);
    cfg.pressureChange = 1;
    tick(1);
    chk("pchg", 1, intSource[1]);
    host.rd(8'h12, d);
    tick(2);
    chk("pchg", 0, intSource[1]);
    cfg.temperatureChange = 1;
    tick(1);
    chk("tchg", 2'b01, intSource[1:0]);
    host.wr(8'h13, 8'h00);
    smp(16'h0002, 8'd21, 1, 0);
    chk("event", 0, dataEvent);
    host.wr(8'h13, 8'h02);
    smp(16'h0003, 8'd21, 1, 0);
    chk("event", 1, dataEvent);
    smp(16'h0003, 8'd21, 0, 1);
    chk("event", 0, dataEvent);
    host.wr(8'h13, 8'h01);
    smp(16'h0003, 8'd21, 0, 1);
    chk("event", 1, dataEvent);
    host.wr(8'h13, 8'h05);
    smp(16'h0003, 8'd21, 0, 1);
    chk("event", 0, dataEvent);
    smp(16'h0003, 8'd22, 0, 1);
    chk("event", 1, dataEvent);
    results();
  end
endmodule : sefl_event_flags_tb
